/* File: bus_partner.sv */
// fieldbus controller model: drives the link state levels
`timescale 1ns/1ns
module bus_partner (
    input  wire logic [2:0] mode,
    output logic            no_data,
    output logic            baud_hunt,
    output logic            conn,
    output logic            data
);
    // ------------------------------
    // link state decode
    // ------------------------------
    // one mode at a time; only conn and data overlap, both set in mode 5
    always_comb
    begin
        no_data   = (mode == 3'h2);
        baud_hunt = (mode == 3'h3);
        conn      = (mode == 3'h4) || (mode == 3'h5);
        data      = (mode == 3'h5);
    end
endmodule : bus_partner

/* File: drive_status_cfg.svh */
// offsets, field positions, reset values and timing for the status block
`ifndef DRIVE_STATUS_CFG_SVH
`define DRIVE_STATUS_CFG_SVH

// ------------------------
// register byte offsets
// ------------------------
`define OFS_CTRL        12'h000
`define OFS_CMD         12'h004
`define OFS_STATUS      12'h008
`define OFS_IRQ_STAT    12'h00c
`define OFS_IRQ_MASK    12'h010

// ------------------------
// control register fields and reset value
// ------------------------
`define CTRL_VARIANT_LO 0
`define CTRL_VARIANT_HI 1
`define CTRL_SWITCH_ON  4
`define CTRL_TMO_LO     8
`define CTRL_TMO_HI     15
`define CTRL_MASK       32'h0000ff13
`define CTRL_RESET      32'h00000000

// unit variants
`define VARIANT_STD     2'h0
`define VARIANT_SERIAL  2'h1
`define VARIANT_NET     2'h2

// ------------------------
// command bits (write-only, self clearing)
// ------------------------
`define CMD_ACK_FAULT   0
`define CMD_ACK_SWAP    1
`define CMD_MANUAL_DONE 2

// ------------------------
// status register bits
// ------------------------
`define ST_FAULT        0
`define ST_ALARM        1
`define ST_RUNNING      2
`define ST_SWAP         3
`define ST_LOADING      4
`define ST_WAIT_MANUAL  5
`define ST_PARAMS_OK    6
`define ST_LAMP_LO      8

// ------------------------
// interrupt bits and widths
// ------------------------
`define IRQ_FAULT       0
`define IRQ_ALARM       1
`define IRQ_SWAP        2
`define IRQ_LOADED      3
`define IRQ_WIDTH       4
`define IRQ_RESET       4'h0

// ------------------------
// lamp indices
// ------------------------
`define LAMP_FAULT      0
`define LAMP_READY      1
`define LAMP_BUS        2
`define LAMP_LINK       3
`define LAMP_TRAFFIC    4
`define LAMP_COUNT      5

// ------------------------
// timing
// ------------------------
`define CLK_HZ          20000000
`define FLASH_HALF_MS   250
`define FLASH_HALF_CYC  (`FLASH_HALF_MS * (`CLK_HZ / 1000))

`endif

/* File: drive_status_indicator.sv */
// fault handling, part swap, parameter auto load and lamps, APB slave
//
// What this block does
// - fault stops converter, lights fault lamp
// - alarms only report, no reaction, no acknowledge
// - switch-on refused until cause gone and acknowledged
// - standard unit: fault prio 2, ready 3
// - bus unit: fault prio 2, ready 4
// - bus no data: bus lamp flashes; the code flashes it only while the timeout field (ctrl bits 15:8) is nonzero
// - baud search: bus lamp steady
// - network link states drive link/traffic lamps
// - loading or commissioning: ready lamp flashes
// - don't-care lamps may show anything
// - part swap message held until acknowledged once parameters are loaded
// - card and select 1/2 loads automatically
// - no card or select 0 waits manual
`include "drive_status_cfg.svh"
`timescale 1ns/1ns
module drive_status_indicator
    import drive_status_pkg::*;
#(
    parameter int FLASH_HALF_CYCLES = `FLASH_HALF_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        fault_in,
    input  wire logic        alarm_in,
    input  wire logic        safety_fault_in,
    input  wire logic        swap_detect,
    input  wire logic        card_present,
    input  wire logic [1:0]  auto_load_select,
    input  wire logic        load_done_in,
    input  wire logic        commissioning_in,
    input  wire logic        bus_no_data,
    input  wire logic        baud_search,
    input  wire logic        net_conn,
    input  wire logic        net_data,
    output logic             converter_enable,
    output logic             load_req,
    output logic             fault_lamp,
    output logic             ready_lamp,
    output logic             bus_fault_lamp,
    output logic             link_lamp,
    output logic             traffic_lamp,
    output logic             irq
);
    import drive_status_pkg::*;

    // ------------------------
    // state
    // ------------------------
    logic [31:0]            ctrl_reg,      ctrl_next;
    logic                   fault_reg,     fault_next;
    logic                   run_reg,       run_next;
    logic                   swap_reg,      swap_next;
    logic                   alarm_reg;
    logic [`IRQ_WIDTH-1:0]  irq_stat_reg,  irq_stat_next;
    logic [`IRQ_WIDTH-1:0]  irq_mask_reg,  irq_mask_next;
    logic                   pready_reg,    pready_next;
    logic [31:0]            prdata_reg,    prdata_next;
    logic                   pslverr_reg,   pslverr_next;
    load_state_t            load_reg,      load_next;
    logic [`LAMP_COUNT-1:0] lamp_reg,      lamp_next;
    logic                   irq_reg,       load_req_reg;
    logic                   flash;
    logic                   wr;
    logic                   rd;
    logic                   mapped;
    logic [31:0]            strb_mask;
    logic [2:0]             cmd;
    logic [`IRQ_WIDTH-1:0]  events;
    logic [31:0]            status;

    lamp_if lamps ();

    // ------------------------
    // apb decode: one wait state, answer registered
    // ------------------------
    assign wr = psel && penable && pwrite && pready_reg;
    assign rd = psel && penable && !pwrite && !pready_reg;
    assign mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_CMD)
                 || (paddr == `OFS_STATUS) || (paddr == `OFS_IRQ_STAT)
                 || (paddr == `OFS_IRQ_MASK);
    assign cmd = (wr && paddr == `OFS_CMD && pstrb[0]) ? pwdata[2:0]
                                                         : 3'h0;

    // byte enables widen to a bit mask
    genvar b;
    generate
        for (b = 0; b < 4; b++)
        begin : g_strb
            assign strb_mask[8*b +: 8] = {8{pstrb[b]}};
        end
    endgenerate

    // ------------------------
    // fault, run, part swap
    // ------------------------
    always_comb
    begin
        fault_next = fault_reg;
        run_next   = run_reg;
        swap_next  = swap_reg;
        if (cmd[`CMD_ACK_FAULT] && !fault_in)
        begin
            fault_next = 1'b0;
        end
        if (fault_in)
        begin
            fault_next = 1'b1;
        end
        run_next = ctrl_reg[`CTRL_SWITCH_ON] && !fault_next;
        if (cmd[`CMD_ACK_SWAP] && load_reg == load_ready)
        begin
            swap_next = 1'b0;
        end
        if (swap_detect)
        begin
            swap_next = 1'b1;
        end
    end

    // ------------------------
    // parameter load sequence
    // ------------------------
    always_comb
    begin
        load_next = load_reg;
        case (load_reg)
            // the selector is a stored setting, sampled once after reset
            load_boot:
            begin
                if (card_present && (auto_load_select == 2'h1
                                  || auto_load_select == 2'h2))
                begin
                    load_next = load_auto;
                end
                else
                begin
                    load_next = load_manual;
                end
            end
            load_auto:
            begin
                if (load_done_in)
                begin
                    load_next = load_ready;
                end
            end
            load_manual:
            begin
                if (cmd[`CMD_MANUAL_DONE])
                begin
                    load_next = load_ready;
                end
            end
            load_ready:
            begin
                load_next = load_ready;
            end
            default:
            begin
                load_next = load_boot;
            end
        endcase
    end

    // ------------------------
    // interrupt status and mask
    // ------------------------
    assign events[`IRQ_FAULT]  = fault_in && !fault_reg;
    assign events[`IRQ_ALARM]  = alarm_in && !alarm_reg;
    assign events[`IRQ_SWAP]   = swap_detect && !swap_reg;
    assign events[`IRQ_LOADED] = (load_reg != load_ready)
                              && (load_next == load_ready);

    always_comb
    begin
        irq_stat_next = irq_stat_reg;
        irq_mask_next = irq_mask_reg;
        if (wr && paddr == `OFS_IRQ_STAT && pstrb[0])
        begin
            irq_stat_next = irq_stat_reg & ~pwdata[`IRQ_WIDTH-1:0];
        end
        if (wr && paddr == `OFS_IRQ_MASK && pstrb[0])
        begin
            irq_mask_next = pwdata[`IRQ_WIDTH-1:0];
        end
        // a new event wins over a clear in the same cycle
        irq_stat_next = irq_stat_next | events;
    end

    // ------------------------
    // register file
    // ------------------------
    always_comb
    begin
        status = 32'h0;
        status[`ST_FAULT]       = fault_reg;
        status[`ST_ALARM]       = alarm_reg;
        status[`ST_RUNNING]     = run_reg;
        status[`ST_SWAP]        = swap_reg;
        status[`ST_LOADING]     = (load_reg == load_auto);
        status[`ST_WAIT_MANUAL] = (load_reg == load_manual);
        status[`ST_PARAMS_OK]   = (load_reg == load_ready);
        status[`ST_LAMP_LO +: `LAMP_COUNT] = lamp_reg;
    end

    always_comb
    begin
        ctrl_next    = ctrl_reg;
        pready_next  = psel && penable && !pready_reg;
        pslverr_next = psel && penable && !pready_reg && !mapped;
        prdata_next  = 32'h0;
        if (wr && paddr == `OFS_CTRL)
        begin
            ctrl_next = (ctrl_reg & ~(strb_mask & `CTRL_MASK))
                      | (pwdata & strb_mask & `CTRL_MASK);
        end
        if (rd)
        begin
            case (paddr)
                `OFS_CTRL:     prdata_next = ctrl_reg;
                `OFS_STATUS:   prdata_next = status;
                `OFS_IRQ_STAT: prdata_next = {28'h0, irq_stat_reg};
                `OFS_IRQ_MASK: prdata_next = {28'h0, irq_mask_reg};
                default:       prdata_next = 32'h0;
            endcase
        end
    end

    // ------------------------
    // lamps
    // ------------------------
    // priority resolution
    assign lamps.variant      = ctrl_reg[`CTRL_VARIANT_HI:`CTRL_VARIANT_LO];
    assign lamps.busy         = commissioning_in || (load_reg == load_auto);
    assign lamps.fault        = fault_reg;
    assign lamps.safety_fault = safety_fault_in;
    assign lamps.bus_no_data  = bus_no_data;
    assign lamps.baud_search  = baud_search;
    assign lamps.net_conn     = net_conn;
    assign lamps.net_data     = net_data;
    assign lamps.bus_mon_on   = |ctrl_reg[`CTRL_TMO_HI:`CTRL_TMO_LO];

    lamp_priority u_prio (
        .lp (lamps.resolver)
    );

    flash_divider #(
        .HALF_CYCLES (FLASH_HALF_CYCLES)
    ) u_flash (
        .pclk    (pclk),
        .presetn (presetn),
        .phase   (flash)
    );

    genvar l;
    generate
        for (l = 0; l < `LAMP_COUNT; l++)
        begin : g_lamp
            assign lamp_next[l] = (lamps.code[l] == lamp_on)
                               || (lamps.code[l] == lamp_flash && flash);
        end
    endgenerate

    // ------------------------
    // registers
    // ------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg     <= `CTRL_RESET;
            fault_reg    <= 1'b0;
            run_reg      <= 1'b0;
            swap_reg     <= 1'b0;
            alarm_reg    <= 1'b0;
            irq_stat_reg <= `IRQ_RESET;
            irq_mask_reg <= `IRQ_RESET;
            pready_reg   <= 1'b0;
            prdata_reg   <= 32'h0;
            pslverr_reg  <= 1'b0;
            load_reg     <= load_boot;
            lamp_reg     <= 5'h0;
            irq_reg      <= 1'b0;
            load_req_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg     <= ctrl_next;
            fault_reg    <= fault_next;
            run_reg      <= run_next;
            swap_reg     <= swap_next;
            alarm_reg    <= alarm_in;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            pready_reg   <= pready_next;
            prdata_reg   <= prdata_next;
            pslverr_reg  <= pslverr_next;
            load_reg     <= load_next;
            lamp_reg     <= lamp_next;
            irq_reg      <= |(irq_stat_next & irq_mask_next);
            load_req_reg <= (load_next == load_auto);
        end
    end

    // ------------------------
    // outputs, all from flip-flops
    // ------------------------
    assign pready           = pready_reg;
    assign prdata           = prdata_reg;
    assign pslverr          = pslverr_reg;
    assign converter_enable = run_reg;
    assign load_req         = load_req_reg;
    assign fault_lamp       = lamp_reg[`LAMP_FAULT];
    assign ready_lamp       = lamp_reg[`LAMP_READY];
    assign bus_fault_lamp   = lamp_reg[`LAMP_BUS];
    assign link_lamp        = lamp_reg[`LAMP_LINK];
    assign traffic_lamp     = lamp_reg[`LAMP_TRAFFIC];
    assign irq              = irq_reg;
endmodule : drive_status_indicator

/* File: drive_status_pkg.sv */
// types shared by the status block and its helpers
package drive_status_pkg;

    // how a lamp is to be shown
    typedef enum logic [1:0] {
        lamp_off,
        lamp_on,
        lamp_flash
    } lamp_code_t;

    // parameter load sequencing after reset
    typedef enum logic [1:0] {
        load_boot,
        load_auto,
        load_manual,
        load_ready
    } load_state_t;

endpackage : drive_status_pkg

/* File: flash_divider.sv */
// square wave that paces every flashing lamp
`timescale 1ns/1ns
module flash_divider #(
    parameter int HALF_CYCLES = 5000000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      phase
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        phase_reg;
    logic        phase_next;

    // count one half period, then flip the phase
    always_comb
    begin
        cnt_next   = cnt_reg + 32'h1;
        phase_next = phase_reg;
        if (cnt_reg >= 32'(HALF_CYCLES - 1))
        begin
            cnt_next   = 32'h0;
            phase_next = ~phase_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg   <= 32'h0;
            phase_reg <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            phase_reg <= phase_next;
        end
    end

    assign phase = phase_reg;
endmodule : flash_divider

/* File: lamp_if.sv */
// indicator states in, resolved lamp codes out
`timescale 1ns/1ns
interface lamp_if;
    import drive_status_pkg::*;

    logic [1:0]  variant;
    logic        busy;
    logic        fault;
    logic        safety_fault;
    logic        bus_no_data;
    logic        baud_search;
    logic        net_conn;
    logic        net_data;
    logic        bus_mon_on;
    lamp_code_t  code [5];

    modport source   (output variant, busy, fault, safety_fault,
                      bus_no_data, baud_search, net_conn, net_data,
                      bus_mon_on, input code);
    modport resolver (input variant, busy, fault, safety_fault,
                      bus_no_data, baud_search, net_conn, net_data,
                      bus_mon_on, output code);
endinterface : lamp_if

/* File: lamp_priority.sv */
// picks the most important indicator state and codes the lamps
`include "drive_status_cfg.svh"
`timescale 1ns/1ns
module lamp_priority (
    lamp_if.resolver lp
);
    import drive_status_pkg::*;

    logic std_unit;
    logic net_unit;
    logic bus_unit;

    assign std_unit = (lp.variant == `VARIANT_STD);
    assign net_unit = (lp.variant == `VARIANT_NET);
    assign bus_unit = !std_unit;

    // walk from priority one downward; first match wins.
    // don't-care lamps default to off, ready to on and link/traffic to flashing on a net unit;
    // the fault lamp follows the fault so a shut-down drive is never dark
    always_comb
    begin
        lp.code[`LAMP_FAULT]   = lp.fault ? lamp_on : lamp_off;
        lp.code[`LAMP_READY]   = lamp_on;
        lp.code[`LAMP_BUS]     = lamp_off;
        lp.code[`LAMP_LINK]    = net_unit ? lamp_flash : lamp_off;
        lp.code[`LAMP_TRAFFIC] = net_unit ? lamp_flash : lamp_off;
        if (lp.busy)
        begin
            lp.code[`LAMP_READY] = lamp_flash;
        end
        else if (std_unit && lp.fault)
        begin
            lp.code[`LAMP_READY] = lamp_off;
        end
        else if (bus_unit && (lp.fault || (net_unit && lp.safety_fault)))
        begin
            lp.code[`LAMP_FAULT] = lamp_on;
            lp.code[`LAMP_READY] = lamp_off;
        end
        else if (bus_unit && lp.baud_search)
        begin
            lp.code[`LAMP_BUS]     = lamp_on;
            lp.code[`LAMP_LINK]    = lamp_off;
            lp.code[`LAMP_TRAFFIC] = lamp_off;
        end
        else if (bus_unit && lp.bus_no_data && lp.bus_mon_on)
        begin
            lp.code[`LAMP_BUS]     = lamp_flash;
            lp.code[`LAMP_LINK]    = lamp_on;
            lp.code[`LAMP_TRAFFIC] = lamp_off;
        end
        else if (net_unit && !lp.net_conn)
        begin
            lp.code[`LAMP_BUS]     = lamp_on;
            lp.code[`LAMP_LINK]    = lamp_off;
            lp.code[`LAMP_TRAFFIC] = lamp_off;
        end
        else if (net_unit)
        begin
            lp.code[`LAMP_LINK]    = lamp_on;
            lp.code[`LAMP_TRAFFIC] = lp.net_data ? lamp_on : lamp_flash;
        end
        // ready state, priority three on standard, four on bus units
        else
        begin
            lp.code[`LAMP_FAULT] = lamp_off;
        end
    end
endmodule : lamp_priority

/* File: status_props.sv */
// assertion checker for the status block ports
`timescale 1ns/1ns
module status_props #(
    parameter int FLASH_HALF_CYCLES = 4
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       fault_in,
    input wire logic       alarm_in,
    input wire logic       commissioning_in,
    input wire logic       card_present,
    input wire logic [1:0] auto_load_select,
    input wire logic       load_done_in,
    input wire logic       load_req,
    input wire logic       converter_enable,
    input wire logic       fault_lamp,
    input wire logic       ready_lamp
);
    // ------------------------------
    // properties
    // ------------------------------
    localparam int FLASH_WIN = FLASH_HALF_CYCLES + 2;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // fault steady with no prio-1 state in the way
    sequence s_fault_held;
        (fault_in && !commissioning_in && !load_req) [*4];
    endsequence
    a_fault_stop: assert property (fault_in |=> !converter_enable)
        else $error("converter ran after fault");
    a_fault_lamp: assert property (fault_in [*3] |-> fault_lamp)
        else $error("fault lamp dark");
    a_fault_dark: assert property (s_fault_held |-> !ready_lamp)
        else $error("ready lamp lit in fault");
    a_stay_off: assert property (
        !converter_enable && fault_in |=> !converter_enable)
        else $error("switch-on during fault");
    a_alarm_quiet: assert property (
        converter_enable && $rose(alarm_in) && !fault_in && !psel
        |=> converter_enable)
        else $error("alarm stopped converter");
    a_busy_flash: assert property (
        commissioning_in [*4] |-> ##[0:FLASH_WIN]
        ($changed(ready_lamp) || !commissioning_in))
        else $error("ready lamp not flashing");
    a_load_cause: assert property (
        $rose(load_req) |-> card_present && auto_load_select != 2'h0)
        else $error("auto load without card");
    a_load_end: assert property (load_req && load_done_in |=> !load_req)
        else $error("load request stuck");
    a_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    a_apb_pulse: assert property (pready |=> !pready)
        else $error("apb ready too long");
endmodule : status_props

bind drive_status_indicator status_props #(
    .FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)
) u_props (
    .pclk, .presetn, .psel, .penable, .pready, .fault_in, .alarm_in,
    .commissioning_in, .card_present, .auto_load_select, .load_done_in,
    .load_req, .converter_enable, .fault_lamp, .ready_lamp
);

/* File: testbench.sv */
// self-checking bench for the drive status block
`timescale 1ns/1ns
`include "drive_status_cfg.svh"
module testbench;
    // ------------------------------
    // signals
    // ------------------------------
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, fault_in = 1'b0, alarm_in = 1'b0;
    logic        swap_detect = 1'b0, card_present = 1'b0;
    logic        load_done_in = 1'b0, commissioning_in = 1'b0;
    logic        pready, pslverr, rerr, converter_enable, load_req, irq;
    logic        bus_no_data, baud_search, net_conn, net_data;
    logic [1:0]  auto_load_select = 2'h0;
    logic [2:0]  mode = 3'h0;
    logic [4:0]  lamp, hi, lo;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    int          n_errors = 0, total_checks = 0, seed = 41, v, s, i, k;
    // lamp model per variant and state: fault ready bus link traffic
    string       tab [4][7] = '{
        '{"01---", "10---", "", "", "", "", "-2---"},
        '{"01---", "10---", "--2--", "--1--", "", "", "-2---"},
        '{"--100", "10-22", "--210", "--100", "--012", "--011", "-2-22"},
        '{"", "", "--0--", "", "", "", ""}};

    drive_status_indicator #(.FLASH_HALF_CYCLES(4)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .pready, .prdata, .pslverr, .fault_in, .alarm_in,
        .safety_fault_in(1'b0), .swap_detect, .card_present,
        .auto_load_select, .load_done_in, .commissioning_in, .bus_no_data,
        .baud_search, .net_conn, .net_data, .converter_enable, .load_req,
        .fault_lamp(lamp[0]), .ready_lamp(lamp[1]), .bus_fault_lamp(lamp[2]),
        .link_lamp(lamp[3]), .traffic_lamp(lamp[4]), .irq);
    bus_partner u_bus (.mode, .no_data(bus_no_data), .baud_hunt(baud_search),
        .conn(net_conn), .data(net_data));

    // 50 ns clock
    initial
    begin
        forever #25 pclk = ~pclk;
    end

    task test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one apb transfer; a stuck slave ends the run
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 8);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_errors++;
            test_done;
        end
    endtask : apb

    task rst;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : rst

    // ------------------------------
    // main sequence
    // ------------------------------
    initial
    begin
        // card fitted, load select 1 or 2, swap during the load
        card_present <= 1'b1;
        auto_load_select <= 2'(($random(seed) & 1) + 1);
        rst;
        chk("load_req", 1, load_req);
        swap_detect <= 1'b1;
        load_done_in <= 1'b1;
        @(posedge pclk);
        swap_detect <= 1'b0;
        load_done_in <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("load_req", 0, load_req);
        apb(0, `OFS_IRQ_STAT, 0);
        chk("irq_stat", 32'hc, rdat & 32'hc);
        apb(1, `OFS_CMD, 32'h2);
        apb(0, `OFS_STATUS, 0);
        chk("status", 32'h40, rdat & 32'h68);
        // no card: manual download, swap held till then
        card_present <= 1'b0;
        rst;
        chk("load_req", 0, load_req);
        swap_detect <= 1'b1;
        @(posedge pclk);
        swap_detect <= 1'b0;
        apb(1, `OFS_CMD, 32'h2);
        apb(0, `OFS_STATUS, 0);
        chk("status", 32'h28, rdat & 32'h68);
        apb(1, `OFS_CMD, 32'h4);
        apb(1, `OFS_CMD, 32'h2);
        apb(0, `OFS_STATUS, 0);
        chk("status", 32'h40, rdat & 32'h68);
        // register reset value, access kinds, unmapped place
        apb(0, `OFS_CTRL, 0);
        chk("ctrl", `CTRL_RESET, rdat);
        apb(0, 12'h020, 0);
        chk("slverr", 1, rerr);
        k = $random(seed);
        apb(1, `OFS_CTRL, k);
        apb(0, `OFS_CTRL, 0);
        chk("ctrl", k & `CTRL_MASK, rdat);
        apb(0, `OFS_CMD, 0);
        chk("cmd", 0, rdat);
        // fault stops the drive until cause gone and acknowledged
        apb(1, `OFS_CTRL, 32'h10);
        repeat (3) @(posedge pclk);
        chk("conv", 1, converter_enable);
        fault_in <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("conv", 0, converter_enable);
        chk("fault_lamp", 1, lamp[0]);
        apb(1, `OFS_CMD, 32'h1);
        repeat (2) @(posedge pclk);
        chk("conv", 0, converter_enable);
        fault_in <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("conv", 0, converter_enable);
        apb(1, `OFS_CMD, 32'h1);
        repeat (3) @(posedge pclk);
        chk("conv", 1, converter_enable);
        // alarm: no reaction; interrupt raised, masked, cleared
        alarm_in <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("conv", 1, converter_enable);
        chk("irq", 0, irq);
        apb(0, `OFS_IRQ_STAT, 0);
        chk("irq_stat", 32'h2, rdat & 32'h2);
        apb(1, `OFS_IRQ_MASK, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq", 1, irq);
        apb(1, `OFS_IRQ_STAT, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq", 0, irq);
        alarm_in <= 1'b0;
        // lamps for every variant and state; row 3 has zero timeout
        for (v = 0; v < 4; v++)
            for (s = 0; s < 7; s++)
                if (tab[v][s] != "")
                begin
                    k = (v == 3) ? 1 : v | (((($random(seed)) & 255) | 1) << 8);
                    apb(1, `OFS_CTRL, k);
                    mode <= (s >= 2 && s <= 5) ? 3'(s) : 3'h0;
                    fault_in <= (s == 1);
                    commissioning_in <= (s == 6);
                    repeat (4) @(posedge pclk);
                    hi = 5'h00;
                    lo = 5'h00;
                    repeat (12)
                    begin
                        @(posedge pclk);
                        hi = hi | lamp;
                        lo = lo | ~lamp;
                    end
                    for (i = 0; i < 5; i++)
                        if (tab[v][s][i] != 8'h2d)
                            chk($sformatf("lamp %0d %0d %0d", v, s, i),
                                32'(tab[v][s][i]) - 32'h30,
                                (hi[i] && lo[i]) ? 2 : hi[i] ? 1 : lo[i] ? 0 : 3);
                    fault_in <= 1'b0;
                    commissioning_in <= 1'b0;
                    mode <= 3'h0;
                    apb(1, `OFS_CMD, 32'h1);
                end
        test_done;
    end
endmodule : testbench
